// >>> logic/lvd_pkg.sv
package lvd_pkg;
  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int ENABLE_BIT      = 7;
  localparam int SOURCE_BIT      = 2;
  localparam int ACTION_BIT      = 1;
  localparam int FLAG_BIT        = 0;
  localparam int RESET_FLAG_BIT  = 0;
  localparam int LEVEL_W         = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET  = 8'h00;
  localparam logic [3:0] LEVEL_RESET   = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int RISE_WINDOW_US  = 1930;
  localparam int STAB_WAIT_US    = 5390;
  // Longest times round down
  localparam int RISE_WINDOW_CYC = RISE_WINDOW_US * (CLK_HZ / 1_000_000);
  localparam int STAB_WAIT_CYC   = STAB_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W           = 18;

  typedef enum logic [1:0]
  {
    LVD_IDLE = 2'b00,
    LVD_RISE = 2'b01,
    LVD_WAIT = 2'b10,
    LVD_DONE = 2'b11
  } lvd_pon_e;
endpackage : lvd_pkg

// >>> logic/lvd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lvd_sync
  import lvd_pkg::*;
(
  input  wire logic CLK,      // System clock
  input  wire logic RESET_N,  // Async reset
  input  wire logic async_in, // Comparator output
  output logic      sync_out  // Filtered level
);
  // ------------------------------------------------------------
  // Three stages; second and third must agree
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0] stage;
    logic       level;
  } lvd_sync_s;

  lvd_sync_s st;
  lvd_sync_s next_st;

  // Compute next state
  always_comb
  begin
    next_st = st;
    next_st.stage = {st.stage[1:0], async_in};
    if (st.stage[1] == st.stage[2])
    begin
      next_st.level = st.stage[2];
    end
  end

  // Register state
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.level;
endmodule : lvd_sync
`default_nettype wire

// >>> logic/lvd_control.sv
// Summary of operation
// - Control bit 2 picks supply (0) or external pin (1) comparison.
// - Control bit 1 picks interrupt (0) or internal reset (1).
// - Reset action holds reset while selected input reads below threshold.
// - Interrupt action pulses a request on each change of selected result.
// - Bit 0 shows live below-threshold result while detector runs.
// - Detector reset sets reset-source bit 0.
// - Software chooses one of sixteen supply levels, 4-bit code out.
// - All logic keeps working in stop mode; no clock gating.
// - High power-on mode: fast rise inserts stabilization wait before reset release.
// - Interrupt request follows flag only when enabled with interrupt action.
// - Enable, source, action clear on resets other than detector reset.
`timescale 1ns/1ps
`default_nettype none
module lvd_control
  import lvd_pkg::*;
#(
  parameter int RISE_CYC = RISE_WINDOW_CYC,
  parameter int WAIT_CYC = STAB_WAIT_CYC
)
(
  input  wire logic               CLK,             // 40 MHz clock
  input  wire logic               RESET_N,         // Power-on / pin reset
  input  wire logic               OTHER_RESET,     // Non-detector system reset
  input  wire logic               STOP_MODE,       // Processor in stop
  input  wire logic               SUPPLY_BELOW,    // Supply comparator, async
  input  wire logic               EXT_BELOW,       // External pin comparator, async
  input  wire logic               POC_LOW_PASS,    // Supply above lower POC, async
  input  wire logic               POC_HIGH_PASS,   // Supply above higher POC, async
  input  wire logic               POWER_ON_THRESHOLD_MODE, // High POC mode
  input  wire logic               CTRL_WE,         // Control write strobe
  input  wire logic [7:0]         CTRL_WDATA,      // Control write data
  input  wire logic               LEVEL_WE,        // Level write strobe
  input  wire logic [LEVEL_W-1:0] LEVEL_WDATA,     // Level write data
  input  wire logic               RSRC_RD,         // Reset-source read, clears
  output logic [7:0]              DETECTOR_CONTROL_REGISTER, // Control readback
  output logic [LEVEL_W-1:0]      DETECT_LEVEL_REGISTER,     // Level code
  output logic [7:0]              RESET_SOURCE_REGISTER,     // Reset source
  output logic                    DETECTOR_INTERRUPT_REQUEST, // Level request
  output logic                    DETECTOR_INTERRUPT_PULSE,   // Edge pulse
  output logic                    DETECTOR_RESET,  // Internal reset out
  output logic                    POC_RESET        // Power-on reset hold
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic               detector_enable;
    logic               detect_source_select;
    logic               detect_action_select;
    logic               below_threshold_flag;
    logic               prev_flag;
    logic [LEVEL_W-1:0] level;
    logic               detector_reset_source_flag;
    logic               irq;
    logic               irq_pulse;
    logic               det_reset;
    logic               poc_reset;
    lvd_pon_e           pon;
    logic [CNT_W-1:0]   cnt;
  } lvd_ctl_s;

  lvd_ctl_s st;
  lvd_ctl_s next_st;
  logic supply_s;
  logic ext_s;
  logic low_s;
  logic high_s;
  logic sel_below;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  lvd_sync u_sync_sup (.CLK(CLK), .RESET_N(RESET_N), .async_in(SUPPLY_BELOW), .sync_out(supply_s));
  lvd_sync u_sync_ext (.CLK(CLK), .RESET_N(RESET_N), .async_in(EXT_BELOW), .sync_out(ext_s));
  lvd_sync u_sync_low (.CLK(CLK), .RESET_N(RESET_N), .async_in(POC_LOW_PASS), .sync_out(low_s));
  lvd_sync u_sync_hi  (.CLK(CLK), .RESET_N(RESET_N), .async_in(POC_HIGH_PASS), .sync_out(high_s));

  // Source mux; STOP_MODE deliberately unused so nothing pauses in stop
  assign sel_below = st.detect_source_select ? ext_s : supply_s;

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.irq_pulse = 1'b0;
    // Flag is zero from the cycle after the detector is disabled
    next_st.below_threshold_flag = st.detector_enable & sel_below;
    next_st.prev_flag = st.below_threshold_flag;
    // Reset action follows the level directly
    next_st.det_reset = st.detector_enable & st.detect_action_select & sel_below;
    next_st.irq = st.detector_enable & ~st.detect_action_select & st.below_threshold_flag;
    if (st.detector_enable && !st.detect_action_select && (st.below_threshold_flag != st.prev_flag))
    begin
      next_st.irq_pulse = 1'b1;
    end
    if (CTRL_WE)
    begin
      next_st.detector_enable      = CTRL_WDATA[ENABLE_BIT];
      next_st.detect_source_select = CTRL_WDATA[SOURCE_BIT];
      next_st.detect_action_select = CTRL_WDATA[ACTION_BIT];
    end
    if (LEVEL_WE)
    begin
      next_st.level = LEVEL_WDATA;
    end
    // Read clears, but a new detector reset wins
    if (RSRC_RD)
    begin
      next_st.detector_reset_source_flag = 1'b0;
    end
    if (st.det_reset)
    begin
      next_st.detector_reset_source_flag = 1'b1;
    end
    // Other resets clear control; detector reset alone keeps it
    if (OTHER_RESET)
    begin
      next_st.detector_enable      = 1'b0;
      next_st.detect_source_select = 1'b0;
      next_st.detect_action_select = 1'b0;
      next_st.level                = LEVEL_RESET;
      next_st.detector_reset_source_flag = st.det_reset;
    end
    // Power-on stabilization sequencer
    case (st.pon)
      LVD_IDLE:
      begin
        next_st.cnt = '0;
        if (low_s)
        begin
          if (POWER_ON_THRESHOLD_MODE)
          begin
            next_st.pon = LVD_RISE;
          end
          else
          begin
            next_st.pon = LVD_DONE;
          end
        end
      end
      LVD_RISE:
      begin
        // Saturate, so a stalled rise can never wrap back into the fast window
        if (st.cnt != {CNT_W{1'b1}})
        begin
          next_st.cnt = st.cnt + 1'b1;
        end
        if (high_s)
        begin
          next_st.cnt = '0;
          next_st.pon = (st.cnt < CNT_W'(RISE_CYC)) ? LVD_WAIT : LVD_DONE;
        end
      end
      LVD_WAIT:
      begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= CNT_W'(WAIT_CYC - 1))
        begin
          next_st.pon = LVD_DONE;
        end
      end
      LVD_DONE:
      begin
        next_st.cnt = '0;
      end
      default:
      begin
        next_st.pon = LVD_IDLE;
      end
    endcase
    if (!low_s)
    begin
      next_st.pon = LVD_IDLE;
    end
    next_st.poc_reset = (next_st.pon != LVD_DONE);
  end

  // Register state; detector is off after power-on reset
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st <= '0;
      st.poc_reset <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign DETECTOR_CONTROL_REGISTER = {st.detector_enable, 4'h0, st.detect_source_select,
                                      st.detect_action_select, st.below_threshold_flag};
  assign DETECT_LEVEL_REGISTER      = st.level;
  assign RESET_SOURCE_REGISTER      = {7'h00, st.detector_reset_source_flag};
  assign DETECTOR_INTERRUPT_REQUEST = st.irq;
  assign DETECTOR_INTERRUPT_PULSE   = st.irq_pulse;
  assign DETECTOR_RESET             = st.det_reset;
  assign POC_RESET                  = st.poc_reset;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_flag_off;
    @(posedge CLK) disable iff (!RESET_N) !st.detector_enable |=> !st.below_threshold_flag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag set while disabled");

  property p_reset_hold;
    @(posedge CLK) disable iff (!RESET_N)
      (st.detector_enable && st.detect_action_select && sel_below) |=> DETECTOR_RESET;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset not held");

  property p_reset_release;
    @(posedge CLK) disable iff (!RESET_N) !sel_below |=> !DETECTOR_RESET;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset not released");

  property p_irq_mode;
    @(posedge CLK) disable iff (!RESET_N) st.detect_action_select |=> !DETECTOR_INTERRUPT_REQUEST;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq in reset action");

  property p_irq_edge;
    @(posedge CLK) disable iff (!RESET_N)
      (st.detector_enable && !st.detect_action_select && $changed(st.below_threshold_flag))
      |=> DETECTOR_INTERRUPT_PULSE;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("missing edge pulse");

  property p_src_flag;
    @(posedge CLK) disable iff (!RESET_N) DETECTOR_RESET |=> RESET_SOURCE_REGISTER[RESET_FLAG_BIT];
  endproperty
  a_src_flag: assert property (p_src_flag) else $error("source flag not set");

  property p_sel_ext;
    @(posedge CLK) disable iff (!RESET_N)
      (st.detector_enable && st.detect_source_select && !CTRL_WE && !OTHER_RESET)
      |=> (st.below_threshold_flag == $past(ext_s));
  endproperty
  a_sel_ext: assert property (p_sel_ext) else $error("wrong source");

  property p_clear;
    @(posedge CLK) disable iff (!RESET_N) OTHER_RESET |=> !st.detector_enable && !st.detect_action_select;
  endproperty
  a_clear: assert property (p_clear) else $error("control not cleared");

  property p_level;
    @(posedge CLK) disable iff (!RESET_N)
      (LEVEL_WE && !OTHER_RESET) |=> DETECT_LEVEL_REGISTER == $past(LEVEL_WDATA);
  endproperty
  a_level: assert property (p_level) else $error("level not stored");

  // Fast rise must enter the stabilisation wait with power-on reset still held
  sequence s_fast_rise;
    (st.pon == LVD_RISE) && high_s && low_s && (st.cnt < CNT_W'(RISE_CYC));
  endsequence
  sequence s_wait_held;
    (st.pon == LVD_WAIT) && POC_RESET;
  endsequence
  property p_fast_wait;
    @(posedge CLK) disable iff (!RESET_N) s_fast_rise |=> s_wait_held;
  endproperty
  a_fast_wait: assert property (p_fast_wait) else $error("no stabilisation wait");
endmodule : lvd_control
`default_nettype wire

// >>> tb/lvd_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lvd_control_tb;
  import lvd_pkg::*;
  // ----------------------------------------------------------
  // Ports and counters
  // ----------------------------------------------------------
  localparam int RISE_T = 20;
  localparam int WAIT_T = 50;
  logic                CLK, RESET_N, OTHER_RESET, STOP_MODE, SUPPLY_BELOW, EXT_BELOW;
  logic                POC_LOW_PASS, POC_HIGH_PASS, POWER_ON_THRESHOLD_MODE;
  logic                CTRL_WE, LEVEL_WE, RSRC_RD;
  logic [7:0]          CTRL_WDATA;
  logic [LEVEL_W-1:0]  LEVEL_WDATA;
  logic [7:0]          DETECTOR_CONTROL_REGISTER, RESET_SOURCE_REGISTER;
  logic [LEVEL_W-1:0]  DETECT_LEVEL_REGISTER;
  logic                DETECTOR_INTERRUPT_REQUEST, DETECTOR_INTERRUPT_PULSE, DETECTOR_RESET, POC_RESET;
  int                  fails, compares, pulses;

  // Short power-on counts keep the run small
  lvd_control #(.RISE_CYC(RISE_T), .WAIT_CYC(WAIT_T)) dut
  (
    .CLK(CLK), .RESET_N(RESET_N), .OTHER_RESET(OTHER_RESET), .STOP_MODE(STOP_MODE),
    .SUPPLY_BELOW(SUPPLY_BELOW), .EXT_BELOW(EXT_BELOW), .POC_LOW_PASS(POC_LOW_PASS),
    .POC_HIGH_PASS(POC_HIGH_PASS), .POWER_ON_THRESHOLD_MODE(POWER_ON_THRESHOLD_MODE),
    .CTRL_WE(CTRL_WE), .CTRL_WDATA(CTRL_WDATA), .LEVEL_WE(LEVEL_WE), .LEVEL_WDATA(LEVEL_WDATA),
    .RSRC_RD(RSRC_RD), .DETECTOR_CONTROL_REGISTER(DETECTOR_CONTROL_REGISTER),
    .DETECT_LEVEL_REGISTER(DETECT_LEVEL_REGISTER), .RESET_SOURCE_REGISTER(RESET_SOURCE_REGISTER),
    .DETECTOR_INTERRUPT_REQUEST(DETECTOR_INTERRUPT_REQUEST),
    .DETECTOR_INTERRUPT_PULSE(DETECTOR_INTERRUPT_PULSE), .DETECTOR_RESET(DETECTOR_RESET),
    .POC_RESET(POC_RESET)
  );

  // Free-running clock, 25 ns period
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Pulses are one cycle wide; count at the falling edge where they are settled
  always @(negedge CLK)
    if (DETECTOR_INTERRUPT_PULSE === 1'b1) pulses++;

  // ----------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Strobes are raised at a falling edge and held over one rising edge
  task automatic wr_ctrl(input logic [7:0] d);
    @(negedge CLK);
    CTRL_WE    = 1'b1;
    CTRL_WDATA = d;
    @(negedge CLK);
    CTRL_WE    = 1'b0;
  endtask : wr_ctrl

  task automatic wr_level(input logic [LEVEL_W-1:0] d);
    @(negedge CLK);
    LEVEL_WE    = 1'b1;
    LEVEL_WDATA = d;
    @(negedge CLK);
    LEVEL_WE    = 1'b0;
  endtask : wr_level

  task automatic strobe_other(input bit rd);
    @(negedge CLK);
    if (rd) RSRC_RD = 1'b1; else OTHER_RESET = 1'b1;
    @(negedge CLK);
    RSRC_RD     = 1'b0;
    OTHER_RESET = 1'b0;
  endtask : strobe_other

  // Async comparator change, then enough cycles for sync, flag and request
  task automatic set_in(input logic sup, input logic ext);
    @(negedge CLK);
    SUPPLY_BELOW = sup;
    EXT_BELOW    = ext;
    repeat (8) @(negedge CLK);
  endtask : set_in

  task automatic do_reset(input logic mode);
    @(negedge CLK);
    RESET_N = 1'b0;
    POC_LOW_PASS = 1'b0;
    POC_HIGH_PASS = 1'b0;
    POWER_ON_THRESHOLD_MODE = mode;
    repeat (6) @(negedge CLK);
    chk({7'h00, POC_RESET}, 8'h01, "poc held in reset");
    RESET_N = 1'b1;
  endtask : do_reset

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #(25 * 5000);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial
  begin
    {OTHER_RESET, STOP_MODE, SUPPLY_BELOW, EXT_BELOW, CTRL_WE, LEVEL_WE, RSRC_RD} = '0;
    {POC_LOW_PASS, POC_HIGH_PASS, POWER_ON_THRESHOLD_MODE} = '0;
    CTRL_WDATA = 8'h00;
    LEVEL_WDATA = 4'h0;
    fails = 0;
    compares = 0;
    pulses = 0;
    RESET_N = 1'b0;
    do_reset(1'b0);
    chk(DETECTOR_CONTROL_REGISTER, CONTROL_RESET, "control after reset");
    chk({4'h0, DETECT_LEVEL_REGISTER}, {4'h0, LEVEL_RESET}, "level after reset");
    chk(RESET_SOURCE_REGISTER, SOURCE_RESET, "source after reset");
    chk({6'h00, DETECTOR_RESET, DETECTOR_INTERRUPT_REQUEST}, 8'h00, "outputs after reset");
    @(negedge CLK);
    POC_LOW_PASS = 1'b1;
    repeat (10) @(negedge CLK);
    chk({7'h00, POC_RESET}, 8'h00, "low mode release");
    $display("Test reset values done");
    // Slow rise in high mode: no extra wait
    do_reset(1'b1);
    POC_LOW_PASS = 1'b1;
    repeat (RISE_T + 10) @(negedge CLK);
    POC_HIGH_PASS = 1'b1;
    repeat (10) @(negedge CLK);
    chk({7'h00, POC_RESET}, 8'h00, "slow rise release");
    // Fast rise in high mode: stabilisation wait inserted
    do_reset(1'b1);
    POC_LOW_PASS = 1'b1;
    POC_HIGH_PASS = 1'b1;
    repeat (WAIT_T - 10) @(negedge CLK);
    chk({7'h00, POC_RESET}, 8'h01, "fast rise still held");
    repeat (40) @(negedge CLK);
    chk({7'h00, POC_RESET}, 8'h00, "fast rise release");
    $display("Test power-on done");
    // Software settling time after release, before any configuration
    repeat (4) @(negedge CLK);
    // All sixteen level codes
    for (int i = 0; i < 16; i++)
    begin
      wr_level(4'(i));
      chk({4'h0, DETECT_LEVEL_REGISTER}, 8'(i), "level code");
    end
    $display("Test level codes done");
    // Interrupt action on the supply input
    wr_ctrl(8'h80);
    chk(DETECTOR_CONTROL_REGISTER, 8'h80, "control write");
    set_in(1'b1, 1'b0);
    chk(DETECTOR_CONTROL_REGISTER, 8'h81, "flag below");
    chk({7'h00, DETECTOR_INTERRUPT_REQUEST}, 8'h01, "request follows flag");
    chk({7'h00, DETECTOR_RESET}, 8'h00, "no reset in irq action");
    set_in(1'b0, 1'b0);
    chk(DETECTOR_CONTROL_REGISTER, 8'h80, "flag above");
    chk({7'h00, DETECTOR_INTERRUPT_REQUEST}, 8'h00, "request drops with flag");
    chk(8'(pulses), 8'h02, "pulse on each change");
    $display("Test interrupt action done");
    // Source select: external pin only
    wr_ctrl(8'h84);
    set_in(1'b1, 1'b0);
    chk(DETECTOR_CONTROL_REGISTER, 8'h84, "supply ignored");
    set_in(1'b1, 1'b1);
    chk(DETECTOR_CONTROL_REGISTER, 8'h85, "external seen");
    set_in(1'b0, 1'b0);
    chk(8'(pulses), 8'h04, "pulses on external changes");
    $display("Test source select done");
    // Reset action, in stop mode
    STOP_MODE = 1'b1;
    wr_ctrl(8'h82);
    set_in(1'b1, 1'b0);
    chk({7'h00, DETECTOR_RESET}, 8'h01, "reset while below");
    chk({7'h00, DETECTOR_INTERRUPT_REQUEST}, 8'h00, "no request in reset action");
    chk(RESET_SOURCE_REGISTER, 8'h01, "reset source set");
    chk(DETECTOR_CONTROL_REGISTER, 8'h83, "control kept");
    set_in(1'b0, 1'b0);
    chk({7'h00, DETECTOR_RESET}, 8'h00, "reset released");
    chk(DETECTOR_CONTROL_REGISTER, 8'h82, "stop mode control");
    strobe_other(1'b1);
    chk(RESET_SOURCE_REGISTER, 8'h00, "source read clears");
    STOP_MODE = 1'b0;
    $display("Test reset action done");
    // Other reset clears control and level
    strobe_other(1'b0);
    chk(DETECTOR_CONTROL_REGISTER, 8'h00, "other reset control");
    chk({4'h0, DETECT_LEVEL_REGISTER}, 8'h00, "other reset level");
    $display("Test other reset done");
    end_of_test();
  end
endmodule : lvd_control_tb
`default_nettype wire
